// >>> verilog/cpu_exec_defs.svh
// constants for the instruction execution subset: fields, opcodes, reset values
// assumes a 14-bit instruction word and an 8-bit data path
`ifndef CPU_EXEC_DEFS_SVH
`define CPU_EXEC_DEFS_SVH

// instruction word fields
`define EX_INSTR_W     14
`define EX_OPC_HI      13
`define EX_OPC_LO      8
`define EX_DEST_BIT    7
`define EX_LIT_HI      7
`define EX_JMP_HI      13
`define EX_JMP_LO      11
`define EX_JMP_K_HI    10

// opcodes of the byte-wide instructions, and the 3-bit code of the jump
`define EX_OPC_CLEAR_FILE_REG    6'h01
`define EX_OPC_CLEAR_ACCUMULATOR    6'h02
`define EX_OPC_DECREMENT_FILE_REG    6'h03
`define EX_OPC_DECSKIP 6'h0B
`define EX_OPC_INCSKIP 6'h0F
`define EX_OPC_ORLIT   6'h38
`define EX_JMP_CODE    3'h5

// high latch bits copied into the upper program counter
`define EX_LATCH_HI    4
`define EX_LATCH_LO    3

// data and counter values
`define EX_BYTE_ZERO   8'h00
`define EX_BYTE_ONE    8'h01
`define EX_PC_RESET    13'h0000
`define EX_PC_STEP     13'h0001
`define EX_PC_SKIP     13'h0002

`endif

// >>> verilog/cpu_exec_pkg.sv
// types for the instruction execution subset
// assumes nothing beyond a SystemVerilog package scope
`default_nettype none

package cpu_exec_pkg;

   typedef enum logic [2:0]
   {
      OP_NOP      = 3'b000,
      OP_CLR_FILE = 3'b001,
      OP_CLR_ACC  = 3'b010,
      OP_DEC_FILE = 3'b011,
      OP_DEC_SKIP = 3'b100,
      OP_INC_SKIP = 3'b101,
      OP_JUMP     = 3'b110,
      OP_OR_LIT   = 3'b111
   } op_t;

   typedef enum logic
   {
      ST_EXEC  = 1'b0,
      ST_FLUSH = 1'b1
   } phase_t;

endpackage

`default_nettype wire

// >>> verilog/exec_alu.sv
// result, destination and flag logic for one decoded instruction
// assumes operands are stable for the whole cycle; purely combinational
`default_nettype none
`include "cpu_exec_defs.svh"

module exec_alu
(
   input  wire cpu_exec_pkg::op_t op,
   input  wire logic [7:0]        accum,
   input  wire logic [7:0]        fileData,
   input  wire logic [7:0]        literal,
   input  wire logic              destFile,
   output logic [7:0]             result,
   output logic                   writeAcc,
   output logic                   writeFile,
   output logic                   zeroUpdate,
   output logic                   zeroValue,
   output logic                   skip
);

   // null test on an 8-bit result
   function automatic logic isNull(input logic [7:0] v);
      isNull = (v == `EX_BYTE_ZERO);
   endfunction

   always_comb
   begin
      result     = `EX_BYTE_ZERO;
      writeAcc   = 1'b0;
      writeFile  = 1'b0;
      zeroUpdate = 1'b0;
      zeroValue  = 1'b0;
      skip       = 1'b0;
      unique case (op)
         cpu_exec_pkg::OP_NOP,
         cpu_exec_pkg::OP_JUMP:
         begin
            result = `EX_BYTE_ZERO;
         end
         cpu_exec_pkg::OP_CLR_FILE:
         begin
            writeFile  = 1'b1;
            zeroUpdate = 1'b1;
            zeroValue  = 1'b1;
         end
         cpu_exec_pkg::OP_CLR_ACC:
         begin
            writeAcc   = 1'b1;
            zeroUpdate = 1'b1;
            zeroValue  = 1'b1;
         end
         cpu_exec_pkg::OP_DEC_FILE:
         begin
            result     = fileData - `EX_BYTE_ONE;
            writeAcc   = !destFile;
            writeFile  = destFile;
            zeroUpdate = 1'b1;
            zeroValue  = isNull(result);
         end
         cpu_exec_pkg::OP_DEC_SKIP:
         begin
            result    = fileData - `EX_BYTE_ONE;
            writeAcc  = !destFile;
            writeFile = destFile;
            skip      = isNull(result);
         end
         cpu_exec_pkg::OP_INC_SKIP:
         begin
            result    = fileData + `EX_BYTE_ONE;
            writeAcc  = !destFile;
            writeFile = destFile;
            skip      = isNull(result);
         end
         cpu_exec_pkg::OP_OR_LIT:
         begin
            result     = accum | literal;
            writeAcc   = 1'b1;
            zeroUpdate = 1'b1;
            zeroValue  = isNull(result);
         end
      endcase
   end

endmodule // exec_alu

`default_nettype wire

// >>> verilog/cpu_instr_exec_subset.sv
// execute stage for a subset of an 8-bit instruction set
// assumes fetch on the same clock; holds accumulator, null flag, pc and data registers
`default_nettype none
`include "cpu_exec_defs.svh"

module cpu_instr_exec_subset
#(
   parameter int DATA_DEPTH = 128,
   parameter int ADDR_W     = 7,
   parameter int PC_W       = 13
)
(
   input  wire logic                   clk,
   input  wire logic                   reset_n,
   input  wire logic                   instrValid,
   input  wire logic [`EX_INSTR_W-1:0] instrWord,
   input  wire logic [7:0]             pcHighLatch,
   output logic                        instrReady,
   output logic [PC_W-1:0]             progCounter,
   output logic [7:0]                  accumulator,
   output logic                        nullFlag,
   output logic                        fileWrEn,
   output logic [ADDR_W-1:0]           fileWrAddr,
   output logic [7:0]                  fileWrData
);

   // state
   cpu_exec_pkg::phase_t phase_r;
   cpu_exec_pkg::phase_t phase_nxt;
   logic                 ready_r;
   logic                 ready_nxt;
   logic [PC_W-1:0]      pc_r;
   logic [PC_W-1:0]      pc_nxt;
   logic [7:0]           acc_r;
   logic [7:0]           acc_nxt;
   logic                 null_r;
   logic                 null_nxt;
   logic                 wrEn_r;
   logic                 wrEn_nxt;
   logic [ADDR_W-1:0]    wrAddr_r;
   logic [ADDR_W-1:0]    wrAddr_nxt;
   logic [7:0]           wrData_r;
   logic [7:0]           wrData_nxt;
   logic [7:0]           fileMem_r   [DATA_DEPTH];
   logic [7:0]           fileMem_nxt [DATA_DEPTH];

   // decode and datapath
   cpu_exec_pkg::op_t    op;
   logic                 take;
   logic [ADDR_W-1:0]    fileAddr;
   logic [7:0]           fileData;
   logic [7:0]           aluResult;
   logic                 aluWriteAcc;
   logic                 aluWriteFile;
   logic                 aluZeroUpdate;
   logic                 aluZeroValue;
   logic                 aluSkip;
   logic [PC_W-1:0]      jumpTarget;

   function automatic cpu_exec_pkg::op_t decodeOp(input logic [`EX_INSTR_W-1:0] w);
      logic [5:0] opc;
      opc = w[`EX_OPC_HI:`EX_OPC_LO];
      if (w[`EX_JMP_HI:`EX_JMP_LO] == `EX_JMP_CODE)
      begin
         decodeOp = cpu_exec_pkg::OP_JUMP;
      end
      else
      begin
         case (opc)
            `EX_OPC_CLEAR_FILE_REG:    decodeOp = cpu_exec_pkg::OP_CLR_FILE;
            `EX_OPC_CLEAR_ACCUMULATOR:    decodeOp = cpu_exec_pkg::OP_CLR_ACC;
            `EX_OPC_DECREMENT_FILE_REG:    decodeOp = cpu_exec_pkg::OP_DEC_FILE;
            `EX_OPC_DECSKIP: decodeOp = cpu_exec_pkg::OP_DEC_SKIP;
            `EX_OPC_INCSKIP: decodeOp = cpu_exec_pkg::OP_INC_SKIP;
            `EX_OPC_ORLIT:   decodeOp = cpu_exec_pkg::OP_OR_LIT;
            // codes outside the subset execute as nop
            default:         decodeOp = cpu_exec_pkg::OP_NOP;
         endcase
      end
   endfunction

   assign op       = decodeOp(instrWord);
   assign take     = instrValid && (phase_r == cpu_exec_pkg::ST_EXEC);
   assign fileAddr = instrWord[ADDR_W-1:0];
   assign fileData = fileMem_r[fileAddr];

   // literal into pc bits 10 to 0
   // upper pc bits from high latch
   assign jumpTarget = PC_W'({pcHighLatch[`EX_LATCH_HI:`EX_LATCH_LO],
                              instrWord[`EX_JMP_K_HI:0]});

   exec_alu u_alu
   (
      .op         (op),
      .accum      (acc_r),
      .fileData   (fileData),
      .literal    (instrWord[`EX_LIT_HI:0]),
      .destFile   (instrWord[`EX_DEST_BIT]),
      .result     (aluResult),
      .writeAcc   (aluWriteAcc),
      .writeFile  (aluWriteFile),
      .zeroUpdate (aluZeroUpdate),
      .zeroValue  (aluZeroValue),
      .skip       (aluSkip)
   );

   always_comb
   begin
      phase_nxt   = cpu_exec_pkg::ST_EXEC;
      ready_nxt   = 1'b1;
      pc_nxt      = pc_r;
      acc_nxt     = acc_r;
      null_nxt    = null_r;
      wrEn_nxt    = 1'b0;
      wrAddr_nxt  = wrAddr_r;
      wrData_nxt  = wrData_r;
      fileMem_nxt = fileMem_r;
      unique case (phase_r)
         cpu_exec_pkg::ST_FLUSH:
         begin
            // second cycle: the discarded slot runs as nop
            phase_nxt = cpu_exec_pkg::ST_EXEC;
            ready_nxt = 1'b1;
         end
         cpu_exec_pkg::ST_EXEC:
         begin
            if (take)
            begin
               pc_nxt = pc_r + PC_W'(`EX_PC_STEP);
               if (aluWriteAcc)
               begin
                  acc_nxt = aluResult;
               end
               if (aluWriteFile)
               begin
                  fileMem_nxt[fileAddr] = aluResult;
                  wrEn_nxt              = 1'b1;
                  wrAddr_nxt            = fileAddr;
                  wrData_nxt            = aluResult;
               end
               // flag only where the op updates it
               if (aluZeroUpdate)
               begin
                  null_nxt = aluZeroValue;
               end
               if (aluSkip)
               begin
                  pc_nxt    = pc_r + PC_W'(`EX_PC_SKIP);
                  phase_nxt = cpu_exec_pkg::ST_FLUSH;
                  ready_nxt = 1'b0;
               end
               if (op == cpu_exec_pkg::OP_JUMP)
               begin
                  pc_nxt    = jumpTarget;
                  phase_nxt = cpu_exec_pkg::ST_FLUSH;
                  ready_nxt = 1'b0;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         phase_r  <= cpu_exec_pkg::ST_EXEC;
         ready_r  <= 1'b1;
         pc_r     <= `EX_PC_RESET;
         acc_r    <= `EX_BYTE_ZERO;
         null_r   <= 1'b0;
         wrEn_r   <= 1'b0;
         wrAddr_r <= '0;
         wrData_r <= `EX_BYTE_ZERO;
         for (int i = 0; i < DATA_DEPTH; i++)
         begin
            fileMem_r[i] <= `EX_BYTE_ZERO;
         end
      end
      else
      begin
         phase_r   <= phase_nxt;
         ready_r   <= ready_nxt;
         pc_r      <= pc_nxt;
         acc_r     <= acc_nxt;
         null_r    <= null_nxt;
         wrEn_r    <= wrEn_nxt;
         wrAddr_r  <= wrAddr_nxt;
         wrData_r  <= wrData_nxt;
         fileMem_r <= fileMem_nxt;
      end
   end

   // outputs straight from registers
   assign instrReady  = ready_r;
   assign progCounter = pc_r;
   assign accumulator = acc_r;
   assign nullFlag    = null_r;
   assign fileWrEn    = wrEn_r;
   assign fileWrAddr  = wrAddr_r;
   assign fileWrData  = wrData_r;

endmodule // cpu_instr_exec_subset

`default_nettype wire

// >>> verif/cpu_exec_assertions.sv
// concurrent checks on the ports of the execution subset
// assumes one clock and the active-low asynchronous reset; bound below
`default_nettype none

module cpu_exec_checker
#(
   parameter int ADDR_W = 7,
   parameter int PC_W   = 13
)
(
   input wire logic              clk,
   input wire logic              reset_n,
   input wire logic              instrValid,
   input wire logic [13:0]       instrWord,
   input wire logic [7:0]        pcHighLatch,
   input wire logic              instrReady,
   input wire logic [PC_W-1:0]   progCounter,
   input wire logic [7:0]        accumulator,
   input wire logic              nullFlag,
   input wire logic              fileWrEn,
   input wire logic [ADDR_W-1:0] fileWrAddr,
   input wire logic [7:0]        fileWrData
);
   logic       take;
   logic       jump;
   logic [5:0] opc;

   assign take = instrValid && instrReady;
   assign jump = take && instrWord[13:11] == 3'h5;
   assign opc  = instrWord[13:8];

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   // one idle slot, then ready again
   sequence nop_slot;
      !instrReady ##1 instrReady;
   endsequence

   jump_target_a:
   assert property (jump |=> progCounter == {$past(pcHighLatch[4:3]), $past(instrWord[10:0])})
      else $error("jump target wrong");
   jump_timing_a:
   assert property (jump |=> nop_slot) else $error("jump not two cycles");
   jump_flags_a:
   assert property (jump |=> $stable(nullFlag) && $stable(accumulator))
      else $error("jump changed state");
   clear_reg_a:
   assert property (take && opc == 6'h01 |=> fileWrEn && fileWrData == 8'h00 && nullFlag
      && fileWrAddr == $past(instrWord[6:0])) else $error("clear register wrong");
   clear_acc_a:
   assert property (take && opc == 6'h02 |=> accumulator == 8'h00 && nullFlag)
      else $error("clear accumulator wrong");
   or_literal_a:
   assert property (take && opc == 6'h38 |=> nullFlag == (accumulator == 8'h00)
      && accumulator == ($past(accumulator) | $past(instrWord[7:0]))) else $error("or wrong");
   dec_file_a:
   assert property (take && opc == 6'h03 |=> fileWrEn == $past(instrWord[7]) && nullFlag ==
      (($past(instrWord[7]) ? fileWrData : accumulator) == 8'h00)) else $error("dec wrong");
   skip_flags_a:
   assert property (take && (opc == 6'h0B || opc == 6'h0F) |=> $stable(nullFlag))
      else $error("skip changed flag");
   skip_nop_a:
   assert property (take && (opc == 6'h0B || opc == 6'h0F) |=> !instrReady ==
      (($past(instrWord[7]) ? fileWrData : accumulator) == 8'h00)) else $error("skip wrong");
   refused_a:
   assert property (!instrReady |=> $stable(progCounter) && $stable(accumulator) && !fileWrEn)
      else $error("nop slot changed state");
endmodule // cpu_exec_checker

bind cpu_instr_exec_subset cpu_exec_checker #(.ADDR_W(ADDR_W), .PC_W(PC_W)) chk
(
   .clk(clk), .reset_n(reset_n), .instrValid(instrValid), .instrWord(instrWord),
   .pcHighLatch(pcHighLatch), .instrReady(instrReady), .progCounter(progCounter),
   .accumulator(accumulator), .nullFlag(nullFlag), .fileWrEn(fileWrEn),
   .fileWrAddr(fileWrAddr), .fileWrData(fileWrData)
);

`default_nettype wire

// >>> verif/cpu_instr_exec_subset_test.sv
// self-checking bench for the execution subset
// assumes the design and checker are compiled first; drives inputs on falling edges
`default_nettype none

module cpu_instr_exec_subset_test;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk;
   logic        reset_n;
   logic        instrValid;
   logic [13:0] instrWord;
   logic [7:0]  pcHighLatch;
   logic        instrReady;
   logic [12:0] progCounter;
   logic [7:0]  accumulator;
   logic        nullFlag;
   logic        fileWrEn;
   logic [6:0]  fileWrAddr;
   logic [7:0]  fileWrData;
   logic [7:0]  regs [128];
   logic [7:0]  eAcc;
   logic [7:0]  eData;
   logic [6:0]  eAddr;
   logic [12:0] ePc;
   logic        eNull;
   logic        eWr;
   logic [19:0] seed;
   logic [5:0]  ops [8] = '{6'h01, 6'h02, 6'h03, 6'h0B, 6'h0F, 6'h38, 6'h2D, 6'h3F};
   int          numErrors;
   int          cmpCount;

   cpu_instr_exec_subset dut
   (
      .clk(clk), .reset_n(reset_n), .instrValid(instrValid), .instrWord(instrWord),
      .pcHighLatch(pcHighLatch), .instrReady(instrReady), .progCounter(progCounter),
      .accumulator(accumulator), .nullFlag(nullFlag), .fileWrEn(fileWrEn),
      .fileWrAddr(fileWrAddr), .fileWrData(fileWrData)
   );

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   function automatic logic [19:0] lfsr(input logic [19:0] s);
      return {s[18:0], s[19] ^ s[16]};
   endfunction

   task automatic chk_val(input string name, input logic [12:0] exp, input logic [12:0] got);
      cmpCount++;
      if (got !== exp)
      begin
         numErrors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic check(input logic rdy);
      chk_val("ready", 13'(rdy), 13'(instrReady));
      chk_val("pc", ePc, progCounter);
      chk_val("acc", 13'(eAcc), 13'(accumulator));
      chk_val("null", 13'(eNull), 13'(nullFlag));
      chk_val("wren", 13'(eWr), 13'(fileWrEn));
      chk_val("wraddr", 13'(eAddr), 13'(fileWrAddr));
      chk_val("wrdata", 13'(eData), 13'(fileWrData));
   endtask

   // expected effect of one taken word
   function automatic void model(input logic [13:0] w, output logic nop);
      logic [7:0] r;
      logic       d;
      d = w[7];
      r = regs[w[6:0]];
      nop = 1'b0;
      eWr = 1'b0;
      ePc = ePc + 13'h0001;
      if (w[13:11] == 3'h5)
      begin
         ePc = {pcHighLatch[4:3], w[10:0]};
         nop = 1'b1;
         return;
      end
      case (w[13:8])
         6'h01: {d, r} = {1'b1, 8'h00};
         6'h02: {d, r} = {1'b0, 8'h00};
         6'h03: r = r - 8'h01;
         6'h0B: r = r - 8'h01;
         6'h0F: r = r + 8'h01;
         6'h38: {d, r} = {1'b0, eAcc | w[7:0]};
         default: return;
      endcase
      if (w[13:8] == 6'h0B || w[13:8] == 6'h0F)
         nop = (r == 8'h00);
      else
         eNull = (r == 8'h00);
      ePc = ePc + {12'h000, nop};
      if (d)
         {regs[w[6:0]], eWr, eAddr, eData} = {r, 1'b1, w[6:0], r};
      else
         eAcc = r;
   endfunction

   // called at a falling edge; a nop slot is tested with a word that must be ignored
   task automatic run(input logic [13:0] w);
      logic nop;
      seed = lfsr(seed);
      instrValid = 1'b1;
      instrWord = w;
      pcHighLatch = seed[7:0];
      model(w, nop);
      @(negedge clk);
      check(!nop);
      if (nop)
      begin
         instrWord = seed[19:6];
         eWr = 1'b0;
         @(negedge clk);
         check(1'b1);
      end
   endtask

   task automatic stop_test;
      $display("compares %0d mismatches %0d", cmpCount, numErrors);
      if (numErrors == 0 && cmpCount > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      #50us;
      numErrors++;
      stop_test;
   end

   initial
   begin
      {reset_n, instrValid, instrWord, pcHighLatch} = '0;
      {eAcc, eData, eAddr, ePc, eNull, eWr} = '0;
      seed = 20'h1_4A90;
      numErrors = 0;
      cmpCount = 0;
      foreach (regs[i])
         regs[i] = 8'h00;
      repeat (16) @(negedge clk);
      reset_n = 1'b1;
      check(1'b1);
      run({6'h38, 8'h00});
      run({6'h38, 8'hA5});
      run({6'h02, 8'h00});
      run({6'h03, 1'b1, 7'h7F});
      run({6'h0F, 1'b1, 7'h7F});
      run({6'h0F, 1'b0, 7'h7F});
      run({6'h0F, 1'b1, 7'h03});
      run({6'h0B, 1'b1, 7'h03});
      run({6'h03, 1'b0, 7'h03});
      run({6'h01, 1'b0, 7'h7F});
      run({3'h5, 11'h7FF});
      run({6'h3F, 8'hFF});
      instrValid = 1'b0;
      @(negedge clk);
      check(1'b1);
      $display("test corner done");
      // mid-run reset: every output but instrReady, and every data register, back to zero
      reset_n = 1'b0;
      @(negedge clk);
      {eAcc, eData, eAddr, ePc, eNull, eWr} = '0;
      foreach (regs[i])
         regs[i] = 8'h00;
      check(1'b1);
      reset_n = 1'b1;
      $display("test reset done");
      repeat (400)
      begin
         seed = lfsr(seed);
         run({ops[seed[2:0]], seed[11], 4'h0, seed[10:8]});
      end
      $display("test random done");
      stop_test;
   end
endmodule // cpu_instr_exec_subset_test

`default_nettype wire
